// *** logic/sca_pkg.sv ***
// Purpose: Constants and types for command admission and status arbitration
// Assumes: One clock, synchronous active-high reset, one command per request pulse
// Notes:   Functional notes below
package sca_pkg;
  localparam int          SCA_NI    = 8;
  localparam int          SCA_IW    = 3;
  localparam logic [7:0]  ST_GOOD   = 8'h00;
  localparam logic [7:0]  ST_CHECK  = 8'h02;
  localparam logic [7:0]  ST_BUSY   = 8'h08;
  localparam logic [7:0]  ST_RESV   = 8'h18;
  localparam logic [7:0]  ST_QFULL  = 8'h28;
  localparam logic [7:0]  INQ_UNK   = 8'h7f;
  localparam logic [2:0]  PFA_UA_MRIE = 3'h2;
  localparam logic [3:0]  KEY_NONE  = 4'h0;
  localparam logic [3:0]  KEY_NRDY  = 4'h2;
  localparam logic [3:0]  KEY_ILL   = 4'h5;
  localparam logic [3:0]  KEY_UA    = 4'h6;
  localparam logic [15:0] ASC_LUNNS = 16'h2500;
  localparam logic [15:0] ASC_OPC   = 16'h2000;
  localparam logic [15:0] ASC_CDB   = 16'h2400;
  localparam logic [15:0] ASC_NRDY  = 16'h0400;
  // UA causes, index 0 ranks highest
  localparam int UA_N     = 7;
  localparam int UA_RESET = 0;
  localparam int UA_CLR   = 1;
  localparam int UA_PR    = 2;
  localparam int UA_FMT   = 3;
  localparam int UA_MCODE = 4;
  localparam int UA_MODE  = 5;
  localparam int UA_LOG   = 6;
  localparam logic [UA_N*16-1:0] UA_ASC = {16'h2a02, 16'h2a01, 16'h3f01, 16'h2800,
                                           16'h2a03, 16'h2f00, 16'h2900};
  typedef enum logic [1:0] {SCA_OP_OTHER, SCA_OP_INQ, SCA_OP_SENSE, SCA_OP_RLUN} sca_op_t;
  typedef struct packed {
    logic [SCA_IW-1:0] init;
    logic [7:0]        lun;
    sca_op_t           op;
    logic              bad_opc;
    logic              bad_cdb;
    logic              resv_conf;
  } sca_cmd_t;
  typedef enum logic [1:0] {SCA_EXEC, SCA_QUEUE, SCA_REJECT} sca_act_t;
  typedef struct packed {
    logic       valid;
    sca_act_t   act;
    logic [7:0] status;
    logic       sense_ok;
    logic [3:0] key;
    logic [15:0] asc;
    logic [7:0] inq_b0;
  } sca_resp_t;
  typedef struct packed {
    logic      io_active;
    logic      wrong_conn;
    logic      deferred;
    logic      startup_fmt;
    logic      q_all_full;
    logic      q_free_full;
    logic      fmt_queued;
    logic      degraded_start_queued;
    logic      sas;
    logic      over_64;
    logic      bus_err;
    logic [2:0] mrie;
  } sca_state_in_t;
  typedef struct packed {
    logic             lun_reset;
    logic             hard_reset;
    logic             mode_ok;
    logic             mode_pages;
    logic             fmt_done;
    logic             mcode_done;
    logic             log_reset;
    logic             clr_task;
    logic [SCA_NI-1:0] clr_had_io;
    logic             pr_clear;
    logic [SCA_IW-1:0] pr_holder;
    logic             pfa;
    logic [SCA_IW-1:0] issuer;
  } sca_ev_t;
endpackage : sca_pkg

// *** logic/sca_admit.sv ***
// Purpose: Decide execute, queue or reject for each command; track UA and sense
// Assumes: Command and event inputs are synchronous one-cycle pulses
// Notes:   Response registered one cycle after cmd_valid
`timescale 1ns/100ps
`default_nettype none
module sca_admit
  import sca_pkg::*;
#(
  parameter int NI = sca_pkg::SCA_NI
)(
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   reset,
  // Command in
  input  wire logic                   cmd_valid,
  input  wire sca_pkg::sca_cmd_t      cmd,
  input  wire sca_pkg::sca_state_in_t st,
  // Events raising unit attention
  input  wire logic                   ev_valid,
  input  wire sca_pkg::sca_ev_t       ev,
  // Answer
  output logic                        ua_any,
  output sca_pkg::sca_resp_t          resp
);
  import sca_pkg::*;

  typedef struct packed {
    logic [NI-1:0][UA_N-1:0] ua;
    logic [NI-1:0]           sn_v;
    logic [NI-1:0][19:0]     sn;
    sca_resp_t               resp;
    logic                    any;
  } sca_regs_t;

  sca_regs_t q, d;

  logic [UA_N-1:0] ua_cur;
  logic [UA_N-1:0] ua_top;
  logic            lun_bad;
  logic            ua_pend;
  logic [15:0]     ua_asc;

  always_comb
  begin
    ua_cur  = q.ua[cmd.init];
    ua_top  = ua_cur & (~ua_cur + 7'h01);
    ua_asc  = 16'h0000;
    for (int k = 0; k < UA_N; k++)
    begin
      if (ua_top[k])
      begin
        ua_asc = UA_ASC[k*16 +: 16];
      end
    end
    lun_bad = (cmd.lun != 8'h00);
    ua_pend = |ua_cur;
  end

  always_comb
  begin
    d = q;
    d.resp.valid = 1'b0;
    // UA set by events
    if (ev_valid)
    begin
      for (int i = 0; i < NI; i++)
      begin
        if (ev.lun_reset || ev.hard_reset)
        begin
          d.ua[i][UA_RESET] = 1'b1;
        end
        if (i != int'(ev.issuer))
        begin
          if (ev.mode_ok && ev.mode_pages)
          begin
            d.ua[i][UA_MODE] = 1'b1;
          end
          if (ev.fmt_done)
          begin
            d.ua[i][UA_FMT] = 1'b1;
          end
          if (ev.mcode_done)
          begin
            d.ua[i][UA_MCODE] = 1'b1;
          end
          if (ev.log_reset)
          begin
            d.ua[i][UA_LOG] = 1'b1;
          end
          if (ev.clr_task && ev.clr_had_io[i])
          begin
            d.ua[i][UA_CLR] = 1'b1;
          end
        end
        if (ev.pr_clear && i == int'(ev.pr_holder))
        begin
          d.ua[i][UA_PR] = 1'b1;
        end
        // No dedicated cause bit; reuses mode-change rank slot for simplicity
        if (ev.pfa && st.mrie == PFA_UA_MRIE)
        begin
          d.ua[i][UA_MODE] = 1'b1;
        end
      end
    end
    if (cmd_valid)
    begin
      d.resp = '0;
      d.resp.valid = 1'b1;
      d.resp.act = SCA_REJECT;
      d.resp.status = ST_CHECK;
      d.resp.sense_ok = 1'b1;
      if (!st.bus_err)
      begin
        // Priority chain, first match wins
        if (lun_bad)
        begin
          d.resp.key = KEY_ILL;
          d.resp.asc = ASC_LUNNS;
          if (cmd.op == SCA_OP_INQ)
          begin
            d.resp.act = SCA_EXEC;
            d.resp.status = ST_GOOD;
            d.resp.sense_ok = 1'b0;
            d.resp.inq_b0 = INQ_UNK;
          end
          else if (cmd.op == SCA_OP_SENSE)
          begin
            d.resp.act = SCA_EXEC;
            d.resp.status = ST_GOOD;
          end
          // Else auto-sense check condition; valid-LUN state untouched
        end
        else
        begin
          // Any later command from the same initiator to the LUN discards its saved sense
          d.sn_v[cmd.init] = 1'b0;
          if (st.wrong_conn)
          begin
            d.resp.key = KEY_ILL;
            d.resp.asc = ASC_OPC;
          end
          else if (ua_pend && (cmd.op == SCA_OP_INQ || cmd.op == SCA_OP_RLUN))
          begin
            d.resp.act = SCA_EXEC;
            d.resp.status = ST_GOOD;
            d.resp.sense_ok = 1'b0;
          end
          else if (ua_pend && cmd.op == SCA_OP_SENSE)
          begin
            d.resp.act = SCA_EXEC;
            d.resp.status = ST_GOOD;
            if (q.sn_v[cmd.init])
            begin
              d.resp.key = q.sn[cmd.init][19:16];
              d.resp.asc = q.sn[cmd.init][15:0];
            end
            else
            begin
              d.resp.key = KEY_UA;
              d.resp.asc = ua_asc;
              d.ua[cmd.init] = d.ua[cmd.init] & ~ua_top;
            end
          end
          else if (ua_pend)
          begin
            d.resp.key = KEY_UA;
            d.resp.asc = ua_asc;
            d.ua[cmd.init] = d.ua[cmd.init] & ~ua_top;
          end
          else if (st.io_active && st.sas && st.over_64)
          begin
            d.resp.status = ST_BUSY;
            d.resp.sense_ok = 1'b0;
          end
          else if (st.io_active && (st.q_all_full || st.q_free_full || st.fmt_queued
                   || st.degraded_start_queued))
          begin
            d.resp.status = ST_QFULL;
            d.resp.sense_ok = 1'b0;
          end
          else if (st.deferred)
          begin
            d.resp.key = KEY_NRDY;
            d.resp.asc = ASC_NRDY;
          end
          else if (st.startup_fmt)
          begin
            d.resp.key = KEY_NRDY;
            d.resp.asc = ASC_NRDY;
          end
          else if (cmd.resv_conf)
          begin
            d.resp.status = ST_RESV;
            d.resp.sense_ok = 1'b0;
          end
          else if (cmd.bad_opc)
          begin
            d.resp.key = KEY_ILL;
            d.resp.asc = ASC_OPC;
          end
          else if (cmd.bad_cdb)
          begin
            d.resp.key = KEY_ILL;
            d.resp.asc = ASC_CDB;
          end
          else if (st.io_active)
          begin
            d.resp.act = SCA_QUEUE;
            d.resp.status = ST_GOOD;
            d.resp.sense_ok = 1'b0;
          end
          else
          begin
            d.resp.act = SCA_EXEC;
            d.resp.status = ST_GOOD;
            d.resp.sense_ok = 1'b0;
          end
          if (d.resp.status == ST_CHECK)
          begin
            d.sn_v[cmd.init] = 1'b1;
            d.sn[cmd.init] = {d.resp.key, d.resp.asc};
          end
        end
      end
      else
      begin
        d.resp.sense_ok = 1'b0;
      end
    end
    d.any = |d.ua;
  end

  always_ff @(posedge clk)
  begin
    if (reset)
    begin
      q <= '0;
      for (int i = 0; i < NI; i++)
      begin
        q.ua[i][UA_RESET] <= 1'b1;
      end
      q.any <= 1'b1;
    end
    else
    begin
      q <= d;
    end
  end

  assign resp   = q.resp;
  assign ua_any = q.any;

  lun_reject_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && lun_bad && cmd.op == SCA_OP_OTHER && !st.bus_err
    |=> resp.valid && resp.act == SCA_REJECT && resp.status == ST_CHECK
    && resp.key == KEY_ILL && resp.asc == ASC_LUNNS)
    else $error("invalid lun not rejected");
  lun_inq_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && lun_bad && cmd.op == SCA_OP_INQ && !st.bus_err
    |=> resp.act == SCA_EXEC && resp.status == ST_GOOD && resp.inq_b0 == INQ_UNK)
    else $error("inquiry to invalid lun wrong");
  lun_sense_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && lun_bad && cmd.op == SCA_OP_SENSE && !st.bus_err
    |=> resp.status == ST_GOOD && resp.key == KEY_ILL && resp.asc == ASC_LUNNS)
    else $error("sense to invalid lun wrong");
  // Event sets excluded so the cleared cause is the only change
  ua_clear_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !lun_bad && !st.bus_err && !st.wrong_conn && ua_pend
    && cmd.op == SCA_OP_OTHER && !ev_valid
    |=> resp.key == KEY_UA && resp.status == ST_CHECK
    && q.ua[$past(cmd.init)] == ($past(ua_cur) & ~$past(ua_top)))
    else $error("unit attention not cleared");
  ua_keep_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !lun_bad && !st.bus_err && !st.wrong_conn && ua_pend && !ev_valid
    && (cmd.op == SCA_OP_INQ || cmd.op == SCA_OP_RLUN)
    |=> resp.act == SCA_EXEC && resp.status == ST_GOOD
    && q.ua[$past(cmd.init)] == $past(ua_cur))
    else $error("inquiry disturbed unit attention");
  sense_keep_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !lun_bad && !st.bus_err && !st.wrong_conn && ua_pend && !ev_valid
    && cmd.op == SCA_OP_SENSE && q.sn_v[cmd.init]
    |=> resp.status == ST_GOOD && {resp.key, resp.asc} == $past(q.sn[cmd.init])
    && q.ua[$past(cmd.init)] == $past(ua_cur))
    else $error("pending sense not returned");
  sense_save_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !lun_bad && !st.bus_err
    |=> q.sn_v[$past(cmd.init)] == (resp.status == ST_CHECK))
    else $error("sense data not tracked");
  busy_sas_a: assert property (@(posedge clk) disable iff (reset)
    resp.valid && resp.status == ST_BUSY |-> $past(st.sas) && $past(st.over_64))
    else $error("busy without sas overflow");
  qfull_a: assert property (@(posedge clk) disable iff (reset)
    resp.valid && resp.status == ST_QFULL |-> !resp.sense_ok && resp.act == SCA_REJECT)
    else $error("queue full with sense");
  startup_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !lun_bad && !ua_pend && !st.io_active && !st.bus_err && !st.wrong_conn
    && !st.deferred && st.startup_fmt
    |=> resp.status == ST_CHECK && resp.key == KEY_NRDY)
    else $error("startup command not refused");
  exec_idle_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && !lun_bad && !ua_pend && !st.io_active && !st.bus_err && !st.wrong_conn
    && !st.deferred && !st.startup_fmt && !cmd.resv_conf && !cmd.bad_opc && !cmd.bad_cdb
    |=> resp.act == SCA_EXEC && resp.status == ST_GOOD)
    else $error("idle command not executed");
  bus_err_a: assert property (@(posedge clk) disable iff (reset)
    cmd_valid && st.bus_err |=> resp.valid && resp.status == ST_CHECK && !resp.sense_ok)
    else $error("bus error answer wrong");
  reset_ua_a: assert property (@(posedge clk)
    $past(reset) && !reset |-> ua_any && !resp.valid)
    else $error("no unit attention after reset");
endmodule : sca_admit
`default_nettype wire

// *** tb/sca_host.sv ***
// Purpose: Initiator model, issues commands and keeps the last answer
// Assumes: Bench asks for one command at a time
// Notes:   Answer held until the next one arrives
`timescale 1ns/100ps
`default_nettype none
module sca_host
  import sca_pkg::*;
(
  // Clock and reset
  input  wire logic               clk,
  input  wire logic               reset,
  // Bench side
  input  wire logic               go,
  input  wire sca_pkg::sca_cmd_t  c_in,
  output var  sca_pkg::sca_resp_t got,
  // Target side
  input  wire sca_pkg::sca_resp_t resp,
  output logic                    cmd_valid,
  output var  sca_pkg::sca_cmd_t  cmd
);
  assign cmd_valid = go;
  assign cmd = c_in;
  always_ff @(posedge clk)
  begin
    if (reset)
      got <= '0;
    else if (resp.valid)
      got <= resp;
  end
endmodule : sca_host
`default_nettype wire

// *** tb/tb_top.sv ***
// Purpose: Self-checking bench for sca_admit
// Assumes: Answer one cycle after each command, events are one-cycle pulses
// Notes:   Xorshift traffic from a fixed seed plus corner cases
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import sca_pkg::*;
  logic              clk = 1'b0;
  logic              reset = 1'b1;
  logic              go = 1'b0;
  logic              ev_valid = 1'b0;
  logic              cmd_valid;
  logic              ua_any;
  sca_cmd_t          c = '0;
  sca_cmd_t          cmd;
  sca_state_in_t     st = '0;
  sca_ev_t           ev = '0;
  sca_resp_t         resp, got, er, mr;
  logic [UA_N-1:0]   ua [SCA_NI];
  logic [19:0]       svd [SCA_NI];
  logic [SCA_NI-1:0] sv = '0;
  logic [SCA_NI-1:0] svm = '0;
  logic [31:0]       rs = 32'h6ca9;
  int                miscompares = 0;
  int                check_count = 0;

  always #20 clk = ~clk;

  sca_admit #(.NI(SCA_NI)) u_sca_admit (.clk(clk), .reset(reset), .cmd_valid(cmd_valid),
    .cmd(cmd), .st(st), .ev_valid(ev_valid), .ev(ev), .ua_any(ua_any), .resp(resp));
  sca_host u_sca_host (.clk(clk), .reset(reset), .go(go), .c_in(c), .got(got),
    .resp(resp), .cmd_valid(cmd_valid), .cmd(cmd));

  function automatic logic [31:0] rnd();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction : rnd

  function automatic int top_ua(input logic [UA_N-1:0] u);
    int t;
    t = -1;
    for (int k = UA_N - 1; k >= 0; k--)
      if (u[k])
        t = k;
    return t;
  endfunction : top_ua

  task automatic chk(input string nm, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic end_sim();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  task automatic rej(input logic [7:0] s, input logic [3:0] k, input logic [15:0] a,
                     input logic ks);
    er.act = SCA_REJECT;
    er.status = s;
    er.key = k;
    er.asc = a;
    er.sense_ok = ks;
    mr.key = {4{ks}};
    mr.asc = {16{ks}};
  endtask : rej

  task automatic do_ev(input sca_ev_t e, input logic [2:0] mrie);
    @(posedge clk);
    ev_valid <= 1'b1;
    ev <= e;
    st.mrie <= mrie;
    for (int i = 0; i < SCA_NI; i++)
    begin
      if (i != int'(e.issuer))
      begin
        ua[i][UA_MODE] |= e.mode_ok && e.mode_pages;
        ua[i][UA_FMT] |= e.fmt_done;
        ua[i][UA_MCODE] |= e.mcode_done;
        ua[i][UA_LOG] |= e.log_reset;
        ua[i][UA_CLR] |= e.clr_task && e.clr_had_io[i];
      end
      ua[i][UA_RESET] |= e.lun_reset || e.hard_reset;
      ua[i][UA_PR] |= e.pr_clear && i == int'(e.pr_holder);
      ua[i][UA_MODE] |= e.pfa && mrie == PFA_UA_MRIE;
    end
    @(posedge clk);
    ev_valid <= 1'b0;
  endtask : do_ev

  task automatic do_cmd(input sca_cmd_t x, input sca_state_in_t s);
    int t;
    int i;
    i = int'(x.init);
    t = top_ua(ua[i]);
    er = '0;
    mr = '0;
    er.valid = 1'b1;
    mr.valid = 1'b1;
    mr.act = sca_act_t'(2'h3);
    mr.status = '1;
    mr.inq_b0 = '1;
    mr.sense_ok = 1'b1;
    if (s.bus_err)
    begin
      rej(ST_CHECK, 4'h0, 16'h0000, 1'b0);
      mr.sense_ok = 1'b1;
    end
    else if (x.lun != 8'h00)
    begin
      if (x.op == SCA_OP_INQ)
        er.inq_b0 = INQ_UNK;
      else
        rej(ST_CHECK, KEY_ILL, ASC_LUNNS, 1'b1);
      if (x.op == SCA_OP_SENSE)
        er.status = ST_GOOD;
      if (x.op == SCA_OP_SENSE)
        er.act = SCA_EXEC;
    end
    else if (s.wrong_conn)
      rej(ST_CHECK, KEY_ILL, ASC_OPC, 1'b1);
    else if (t >= 0 && x.op != SCA_OP_OTHER)
    begin
      // These execute with good status; sense without saved data clears the top attention, the rest keep it
      if (x.op == SCA_OP_SENSE && sv[i])
      begin
        {er.key, er.asc} = svd[i];
        er.sense_ok = 1'b1;
        mr.key = '1;
        mr.asc = {16{svm[i]}};
      end
      else if (x.op == SCA_OP_SENSE)
      begin
        rej(ST_GOOD, KEY_UA, UA_ASC[t*16 +: 16], 1'b1);
        er.act = SCA_EXEC;
        ua[i][t] = 1'b0;
      end
    end
    else if (t >= 0)
    begin
      rej(ST_CHECK, KEY_UA, UA_ASC[t*16 +: 16], 1'b1);
      ua[i][t] = 1'b0;
    end
    else if (s.io_active && s.sas && s.over_64)
      rej(ST_BUSY, 4'h0, 16'h0000, 1'b0);
    else if (s.io_active && (s.q_all_full || s.q_free_full || s.fmt_queued
                             || s.degraded_start_queued))
    begin
      rej(ST_QFULL, 4'h0, 16'h0000, 1'b0);
      mr.sense_ok = 1'b1;
    end
    else if (s.deferred)
    begin
      rej(ST_CHECK, KEY_NRDY, ASC_NRDY, 1'b1);
    end
    else if (s.startup_fmt)
      rej(ST_CHECK, KEY_NRDY, ASC_NRDY, 1'b1);
    else if (x.resv_conf)
      rej(ST_RESV, 4'h0, 16'h0000, 1'b0);
    else if (x.bad_opc)
      rej(ST_CHECK, KEY_ILL, ASC_OPC, 1'b1);
    else if (x.bad_cdb)
      rej(ST_CHECK, KEY_ILL, ASC_CDB, 1'b1);
    else if (s.io_active)
    begin
      er.act = SCA_QUEUE;
    end
    @(posedge clk);
    go <= 1'b1;
    c <= x;
    st <= s;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
    chk("resp", got & mr, er & mr);
    chk("resp pulse", resp.valid, 1'b0);
    if (!s.bus_err && x.lun == 8'h00)
    begin
      sv[i] = er.status == ST_CHECK;
      svm[i] = mr.asc[0];
      svd[i] = {er.key, er.asc};
    end
    t = 0;
    for (int j = 0; j < SCA_NI; j++)
      t = t | int'(ua[j] != '0);
    chk("ua_any", ua_any, t[0]);
  endtask : do_cmd

  initial
  begin
    sca_cmd_t      x;
    sca_state_in_t s;
    sca_ev_t       e;
    for (int i = 0; i < SCA_NI; i++)
      ua[i] = 7'h01;
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    #1;
    chk("reset resp", resp, 64'h0);
    chk("reset ua_any", ua_any, 1'b1);
    x = '0;
    s = '0;
    x.init = 3'h1;
    x.lun = 8'h05;
    do_cmd(x, s);
    x.lun = 8'h00;
    x.op = SCA_OP_INQ;
    do_cmd(x, s);
    x.op = SCA_OP_RLUN;
    do_cmd(x, s);
    x.op = SCA_OP_SENSE;
    do_cmd(x, s);
    x.init = 3'h2;
    x.op = SCA_OP_OTHER;
    s.io_active = 1'b1;
    s.q_all_full = 1'b1;
    do_cmd(x, s);
    e = '0;
    e.pfa = 1'b1;
    do_ev(e, PFA_UA_MRIE);
    x = '0;
    s = '0;
    x.init = 3'h2;
    x.op = SCA_OP_SENSE;
    do_cmd(x, s);
    x.op = SCA_OP_OTHER;
    s.io_active = 1'b1;
    s.sas = 1'b1;
    s.over_64 = 1'b1;
    do_cmd(x, s);
    do_cmd(x, s);
    s = '0;
    s.deferred = 1'b1;
    do_cmd(x, s);
    s = '0;
    s.startup_fmt = 1'b1;
    do_cmd(x, s);
    s = '0;
    x.resv_conf = 1'b1;
    x.bad_opc = 1'b1;
    do_cmd(x, s);
    x.resv_conf = 1'b0;
    x.bad_cdb = 1'b1;
    do_cmd(x, s);
    x.bad_opc = 1'b0;
    do_cmd(x, s);
    x.bad_cdb = 1'b0;
    s.io_active = 1'b1;
    do_cmd(x, s);
    s.io_active = 1'b0;
    do_cmd(x, s);
    x.init = 3'h3;
    s.startup_fmt = 1'b1;
    do_cmd(x, s);
    s.bus_err = 1'b1;
    x.lun = 8'h03;
    do_cmd(x, s);
    for (int n = 0; n < 600; n++)
    begin
      if ((rnd() & 32'h7) == 32'h0)
      begin
        e = sca_ev_t'(24'(rnd() & rnd() & rnd()));
        e.issuer = 3'(rnd());
        e.pr_holder = 3'(rnd());
        do_ev(e, 3'(rnd()));
      end
      else
      begin
        x = sca_cmd_t'(16'(rnd()));
        s = sca_state_in_t'(14'(rnd() & rnd()));
        if ((rnd() & 32'h3) != 32'h0)
          x.lun = 8'h00;
        // Special ops under startup or reservation are left open
        if (x.op != SCA_OP_OTHER || rnd() > 32'h80000000)
        begin
          {s.deferred, s.startup_fmt, s.q_all_full, s.q_free_full, s.wrong_conn} = '0;
          {s.fmt_queued, s.degraded_start_queued, s.over_64} = '0;
          {x.resv_conf, x.bad_opc, x.bad_cdb} = '0;
        end
        if (s.q_all_full || s.q_free_full || s.fmt_queued || s.degraded_start_queued)
          s.over_64 = 1'b0;
        s.bus_err = s.bus_err && ((rnd() & 32'h7) == 32'h0);
        do_cmd(x, s);
      end
    end
    end_sim();
  end

  initial
  begin
    #400000;
    miscompares++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
